//--- fmbm_pkg.sv
// constants, field layouts and helpers shared by the float-mode background monitor
package fmbm_pkg;

  localparam int          FMBM_CHANNELS        = 4;
  localparam int          FMBM_SAMPLE_W        = 14;
  localparam int          FMBM_COUNT_W         = 5;

  // register addresses as printed
  localparam logic [7:0]  FMBM_ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  FMBM_ADDR_THRESH_A   = 8'h16;
  localparam logic [7:0]  FMBM_ADDR_THRESH_B   = 8'h1c;
  localparam logic [7:0]  FMBM_ADDR_TIMING_A   = 8'h3e;
  localparam logic [7:0]  FMBM_ADDR_TIMING_B   = 8'h3f;

  // field positions
  localparam int          FMBM_FLAGS_A_LSB     = 0;
  localparam int          FMBM_FLAGS_B_LSB     = 4;
  localparam int          FMBM_SEL_LSB         = 14;
  localparam int          FMBM_THRESH_LSB      = 0;
  localparam int          FMBM_WIDTH_LSB       = 8;
  localparam int          FMBM_DELAY_LSB       = 0;

  // values after reset
  localparam logic [1:0]  FMBM_RST_COUNT_SEL   = 2'h0;
  localparam logic [13:0] FMBM_RST_THRESH      = 14'h0000;
  localparam logic [1:0]  FMBM_RST_EMITTER_SEL = 2'h0;
  localparam logic [4:0]  FMBM_RST_PULSE_WIDTH = 5'h03;
  localparam logic [7:0]  FMBM_RST_FIRST_DELAY = 8'h20;

  // exceedances needed per count setting; zero means never
  localparam logic [4:0]  FMBM_NEED_NEVER      = 5'h00;
  localparam logic [4:0]  FMBM_NEED_ONE        = 5'h01;
  localparam logic [4:0]  FMBM_NEED_FOUR       = 5'h04;
  localparam logic [4:0]  FMBM_NEED_SIXTEEN    = 5'h10;

  function automatic logic [4:0] fmbm_need(input logic [1:0] sel);
    case (sel)
      2'h1:    fmbm_need = FMBM_NEED_ONE;
      2'h2:    fmbm_need = FMBM_NEED_FOUR;
      2'h3:    fmbm_need = FMBM_NEED_SIXTEEN;
      default: fmbm_need = FMBM_NEED_NEVER;
    endcase
  endfunction

endpackage

//--- fmbm_exceed_counter.sv
// one channel's exceed counter with its sticky flag
`timescale 1ns/1ns
module fmbm_exceed_counter
  import fmbm_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // events
  input  wire logic                    hit,
  input  wire logic                    clear,
  input  wire logic [FMBM_COUNT_W-1:0] need,
  // state
  output logic                         flag
);

  logic [FMBM_COUNT_W-1:0] count;
  logic [FMBM_COUNT_W-1:0] next_count;
  logic [FMBM_COUNT_W-1:0] bumped;
  logic                    next_flag;

  always_comb begin
    next_count = count;
    next_flag  = flag;
    bumped     = (count == FMBM_NEED_SIXTEEN) ? count : count + 5'h01;
    if (clear) begin
      next_count = 5'h00;  // [RQ13]
      next_flag  = 1'b0;   // [RQ3]
    end
    if (hit) begin
      // a hit in the clearing cycle counts as the first of a new run
      next_count = clear ? 5'h01 : bumped;  // [RQ4] [RQ5]
      // setting zero leaves the flag alone; set wins over the read clear
      if (need != FMBM_NEED_NEVER && (clear ? 5'h01 : bumped) >= need) begin
        next_flag = 1'b1;  // [RQ6] [RQ7] [RQ13]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= 5'h00;
      flag  <= 1'b0;
    end else begin
      count <= next_count;
      flag  <= next_flag;
    end
  end

endmodule

//--- fmbm_monitor.sv
// float-mode background monitor: thresholds, exceed counting, status and float LED timing
//
// Overview of operation
// [RQ1] Slot A exceed flags read at status bits 3..0, channel 1 at bit 0.
// [RQ2] Slot B exceed flags read at status bits 7..4, channel 1 at bit 4.
// [RQ3] Reading the status register clears all flags; flags stay until read. A hit in the read cycle at count setting 1 still sets its flag.
// [RQ4] Slot A subtract samples above the 14-bit slot A limit bump that count.
// [RQ5] Slot B subtract samples above the 14-bit slot B limit bump that count.
// [RQ6] Slot A count setting: 0 never, 1/2/3 need 1/4/16 exceedances.
// [RQ7] Slot B count setting: 0 never, 1/2/3 need 1/4/16 exceedances.
// [RQ8] Slot A emitter select: 0 none, 1..3 pick first..third LED driver.
// [RQ9] Slot B emitter select in bits 15:14; zero drives no LED.
// [RQ10] Slot A float pulse width, 5 bits in 1 us steps, resets to 3.
// [RQ11] Slot A first pulse delay, 8 bits, resets to 32.
// [RQ12] Slot B float pulse width, 5 bits in 1 us steps, resets to 3.
// [RQ13] Counter restarts at zero on read clear; setting zero keeps flag clear.
`timescale 1ns/1ns
module fmbm_monitor
  import fmbm_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // register access from the serial port logic
  input  wire logic [7:0]               regAddr,
  input  wire logic                     regWrite,
  input  wire logic [15:0]              regWriteData,
  input  wire logic                     regRead,
  output logic      [15:0]              regReadData,
  // conversion results from the sequencer
  input  wire logic                     sampleValid,
  input  wire logic                     sampleSubtract,
  input  wire logic                     sampleSlotB,
  input  wire logic [1:0]               sampleChannel,
  input  wire logic [FMBM_SAMPLE_W-1:0] sampleData,
  // float LED settings toward the pulse sequencer
  output logic      [1:0]               slot_a_float_emitter_sel,
  output logic      [4:0]               slot_a_float_pulse_width,
  output logic      [7:0]               slot_a_float_first_pulse_delay,
  output logic      [1:0]               slot_b_float_emitter_sel,
  output logic      [4:0]               slot_b_float_pulse_width,
  output logic      [7:0]               slot_b_float_first_pulse_delay,
  // status view
  output logic      [3:0]               slot_a_exceed_flags,
  output logic      [3:0]               slot_b_exceed_flags
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers shared by both slots

  // strictly greater: a result equal to the limit is not an exceedance
  function automatic logic fmbm_exceeds(
    input logic [13:0] data,
    input logic [13:0] limit
  );
    fmbm_exceeds = data > limit;
  endfunction

  // bit 13 of a timing word is reserved: never stored, always reads zero
  function automatic logic [15:0] fmbm_timing_word(
    input logic [1:0] sel,
    input logic [4:0] width,
    input logic [7:0] delay
  );
    fmbm_timing_word = {sel, 1'b0, width, delay};
  endfunction

  function automatic logic [15:0] fmbm_limit_word(
    input logic [1:0]  sel,
    input logic [13:0] limit
  );
    fmbm_limit_word = {sel, limit};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [1:0]  slot_a_exceed_count_sel;
  logic [1:0]  slot_b_exceed_count_sel;
  logic [13:0] slot_a_ambient_limit;
  logic [13:0] slot_b_ambient_limit;
  logic [1:0]  next_slot_a_exceed_count_sel;
  logic [1:0]  next_slot_b_exceed_count_sel;
  logic [13:0] next_slot_a_ambient_limit;
  logic [13:0] next_slot_b_ambient_limit;
  logic [1:0]  next_slot_a_float_emitter_sel;
  logic [1:0]  next_slot_b_float_emitter_sel;
  logic [4:0]  next_slot_a_float_pulse_width;
  logic [4:0]  next_slot_b_float_pulse_width;
  logic [7:0]  next_slot_a_float_first_pulse_delay;
  logic [7:0]  next_slot_b_float_first_pulse_delay;

  always_comb begin
    next_slot_a_exceed_count_sel        = slot_a_exceed_count_sel;
    next_slot_b_exceed_count_sel        = slot_b_exceed_count_sel;
    next_slot_a_ambient_limit           = slot_a_ambient_limit;
    next_slot_b_ambient_limit           = slot_b_ambient_limit;
    next_slot_a_float_emitter_sel       = slot_a_float_emitter_sel;
    next_slot_b_float_emitter_sel       = slot_b_float_emitter_sel;
    next_slot_a_float_pulse_width       = slot_a_float_pulse_width;
    next_slot_b_float_pulse_width       = slot_b_float_pulse_width;
    next_slot_a_float_first_pulse_delay = slot_a_float_first_pulse_delay;
    next_slot_b_float_first_pulse_delay = slot_b_float_first_pulse_delay;
    if (regWrite) begin
      case (regAddr)
        FMBM_ADDR_THRESH_A: begin
          next_slot_a_exceed_count_sel = regWriteData[FMBM_SEL_LSB +: 2];     // [RQ6]
          next_slot_a_ambient_limit    = regWriteData[FMBM_THRESH_LSB +: 14]; // [RQ4]
        end
        FMBM_ADDR_THRESH_B: begin
          next_slot_b_exceed_count_sel = regWriteData[FMBM_SEL_LSB +: 2];     // [RQ7]
          next_slot_b_ambient_limit    = regWriteData[FMBM_THRESH_LSB +: 14]; // [RQ5]
        end
        FMBM_ADDR_TIMING_A: begin
          next_slot_a_float_emitter_sel       = regWriteData[FMBM_SEL_LSB +: 2];   // [RQ8]
          next_slot_a_float_pulse_width       = regWriteData[FMBM_WIDTH_LSB +: 5]; // [RQ10]
          next_slot_a_float_first_pulse_delay = regWriteData[FMBM_DELAY_LSB +: 8]; // [RQ11]
        end
        FMBM_ADDR_TIMING_B: begin
          next_slot_b_float_emitter_sel       = regWriteData[FMBM_SEL_LSB +: 2];   // [RQ9]
          next_slot_b_float_pulse_width       = regWriteData[FMBM_WIDTH_LSB +: 5]; // [RQ12]
          next_slot_b_float_first_pulse_delay = regWriteData[FMBM_DELAY_LSB +: 8];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      slot_a_exceed_count_sel        <= FMBM_RST_COUNT_SEL;
      slot_b_exceed_count_sel        <= FMBM_RST_COUNT_SEL;
      slot_a_ambient_limit           <= FMBM_RST_THRESH;
      slot_b_ambient_limit           <= FMBM_RST_THRESH;
      slot_a_float_emitter_sel       <= FMBM_RST_EMITTER_SEL;
      slot_b_float_emitter_sel       <= FMBM_RST_EMITTER_SEL;
      slot_a_float_pulse_width       <= FMBM_RST_PULSE_WIDTH;  // [RQ10]
      slot_b_float_pulse_width       <= FMBM_RST_PULSE_WIDTH;  // [RQ12]
      slot_a_float_first_pulse_delay <= FMBM_RST_FIRST_DELAY;  // [RQ11]
      slot_b_float_first_pulse_delay <= FMBM_RST_FIRST_DELAY;
    end else begin
      slot_a_exceed_count_sel        <= next_slot_a_exceed_count_sel;
      slot_b_exceed_count_sel        <= next_slot_b_exceed_count_sel;
      slot_a_ambient_limit           <= next_slot_a_ambient_limit;
      slot_b_ambient_limit           <= next_slot_b_ambient_limit;
      slot_a_float_emitter_sel       <= next_slot_a_float_emitter_sel;
      slot_b_float_emitter_sel       <= next_slot_b_float_emitter_sel;
      slot_a_float_pulse_width       <= next_slot_a_float_pulse_width;
      slot_b_float_pulse_width       <= next_slot_b_float_pulse_width;
      slot_a_float_first_pulse_delay <= next_slot_a_float_first_pulse_delay;
      slot_b_float_first_pulse_delay <= next_slot_b_float_first_pulse_delay;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exceed detection and per-channel counters

  logic       statusRead;
  logic [3:0] hitA;
  logic [3:0] hitB;

  assign statusRead = regRead && (regAddr == FMBM_ADDR_STATUS);  // [RQ3]

  always_comb begin
    hitA = 4'h0;
    hitB = 4'h0;
    // only subtract-cycle samples are judged; strictly greater than the limit
    if (sampleValid && sampleSubtract) begin
      if (!sampleSlotB && fmbm_exceeds(sampleData, slot_a_ambient_limit)) begin
        hitA[sampleChannel] = 1'b1;  // [RQ4]
      end
      if (sampleSlotB && fmbm_exceeds(sampleData, slot_b_ambient_limit)) begin
        hitB[sampleChannel] = 1'b1;  // [RQ5]
      end
    end
  end

  for (genvar ch = 0; ch < FMBM_CHANNELS; ch++) begin : gChannel
    fmbm_exceed_counter uCountA (
      .clk   (clk),
      .reset (reset),
      .hit   (hitA[ch]),
      .clear (statusRead),
      .need  (fmbm_need(slot_a_exceed_count_sel)),  // [RQ6]
      .flag  (slot_a_exceed_flags[ch])               // [RQ1]
    );
    fmbm_exceed_counter uCountB (
      .clk   (clk),
      .reset (reset),
      .hit   (hitB[ch]),
      .clear (statusRead),
      .need  (fmbm_need(slot_b_exceed_count_sel)),  // [RQ7]
      .flag  (slot_b_exceed_flags[ch])               // [RQ2]
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data; registered so the returned status is the value before clearing

  logic [15:0] next_regReadData;

  always_comb begin
    next_regReadData = regReadData;
    if (regRead) begin
      case (regAddr)
        FMBM_ADDR_STATUS:   next_regReadData = {8'h00, slot_b_exceed_flags, slot_a_exceed_flags};  // [RQ1] [RQ2]
        FMBM_ADDR_THRESH_A: next_regReadData = fmbm_limit_word(slot_a_exceed_count_sel, slot_a_ambient_limit);
        FMBM_ADDR_THRESH_B: next_regReadData = fmbm_limit_word(slot_b_exceed_count_sel, slot_b_ambient_limit);
        FMBM_ADDR_TIMING_A: next_regReadData = fmbm_timing_word(slot_a_float_emitter_sel, slot_a_float_pulse_width,
                                                                slot_a_float_first_pulse_delay);
        FMBM_ADDR_TIMING_B: next_regReadData = fmbm_timing_word(slot_b_float_emitter_sel, slot_b_float_pulse_width,
                                                                slot_b_float_first_pulse_delay);
        default:            next_regReadData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      regReadData <= 16'h0000;
    end else begin
      regReadData <= next_regReadData;
    end
  end

endmodule

//--- fmbm_monitor_sva.sv
// concurrent checks on the ports of the float-mode background monitor
`timescale 1ns/1ns
module fmbm_monitor_sva
  import fmbm_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic        regWrite,
  input wire logic [15:0] regWriteData,
  input wire logic        regRead,
  input wire logic [15:0] regReadData,
  // samples
  input wire logic        sampleValid,
  input wire logic        sampleSubtract,
  input wire logic        sampleSlotB,
  input wire logic [1:0]  sampleChannel,
  input wire logic [13:0] sampleData,
  // settings and status
  input wire logic [1:0]  slot_a_float_emitter_sel,
  input wire logic [4:0]  slot_a_float_pulse_width,
  input wire logic [7:0]  slot_a_float_first_pulse_delay,
  input wire logic [1:0]  slot_b_float_emitter_sel,
  input wire logic [4:0]  slot_b_float_pulse_width,
  input wire logic [7:0]  slot_b_float_first_pulse_delay,
  input wire logic [3:0]  slot_a_exceed_flags,
  input wire logic [3:0]  slot_b_exceed_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // shadow limits so hits can be judged from the write strobes alone
  logic [15:0] limA;
  logic [15:0] limB;
  logic        rdStat;
  logic        hitA;
  logic        hitB;
  logic [14:0] wrCfg;
  always_ff @(posedge clk) begin
    if (reset) begin
      limA <= 16'h0000;
      limB <= 16'h0000;
    end else if (regWrite && regAddr == FMBM_ADDR_THRESH_A) begin
      limA <= regWriteData;
    end else if (regWrite && regAddr == FMBM_ADDR_THRESH_B) begin
      limB <= regWriteData;
    end
  end
  assign rdStat = regRead && regAddr == FMBM_ADDR_STATUS;
  assign hitA   = sampleValid && sampleSubtract && !sampleSlotB && sampleData > limA[13:0];
  assign hitB   = sampleValid && sampleSubtract && sampleSlotB && sampleData > limB[13:0];
  assign wrCfg  = {regWriteData[15:14], regWriteData[12:0]};
  a_status_a_bits: assert property (rdStat |=> regReadData[3:0] == $past(slot_a_exceed_flags))
    else $error("status bits 3:0 wrong");
  a_status_b_bits: assert property (rdStat |=> regReadData[7:4] == $past(slot_b_exceed_flags))
    else $error("status bits 7:4 wrong");
  a_read_clears: assert property (rdStat && !sampleValid |=> {slot_b_exceed_flags, slot_a_exceed_flags} == 8'h00)
    else $error("flags survive a status read");
  a_flags_sticky: assert property (!rdStat |=> (slot_a_exceed_flags & $past(slot_a_exceed_flags)) == $past(slot_a_exceed_flags))
    else $error("flag dropped without a read");
  a_rise_needs_hitA: assert property (!hitA |=> (slot_a_exceed_flags & ~$past(slot_a_exceed_flags)) == 4'h0)
    else $error("slot A flag rose without a hit");
  a_rise_needs_hitB: assert property (!hitB |=> (slot_b_exceed_flags & ~$past(slot_b_exceed_flags)) == 4'h0)
    else $error("slot B flag rose without a hit");
  a_single_hit_sets: assert property (hitA && limA[15:14] == 2'h1 |=> slot_a_exceed_flags[$past(sampleChannel)])
    else $error("one hit did not set slot A flag");
  a_timing_a_write: assert property (regWrite && regAddr == FMBM_ADDR_TIMING_A |=>
    {slot_a_float_emitter_sel, slot_a_float_pulse_width, slot_a_float_first_pulse_delay} == $past(wrCfg))
    else $error("slot A timing outputs wrong");
  a_timing_b_write: assert property (regWrite && regAddr == FMBM_ADDR_TIMING_B |=>
    {slot_b_float_emitter_sel, slot_b_float_pulse_width, slot_b_float_first_pulse_delay} == $past(wrCfg))
    else $error("slot B timing outputs wrong");
endmodule
bind fmbm_monitor fmbm_monitor_sva u_sva (.*);

//--- fmbm_monitor_tb.sv
// self-checking bench for the float-mode background monitor
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; $display("Error %0t: mismatch got %h expected %h", $time, a, b); end end
module fmbm_monitor_tb
  import fmbm_pkg::*;
;
  logic        clk, reset, regWrite, regRead, sampleValid, sampleSubtract, sampleSlotB;
  logic [7:0]  regAddr, slot_a_float_first_pulse_delay, slot_b_float_first_pulse_delay;
  logic [15:0] regWriteData, regReadData, rd;
  logic [1:0]  sampleChannel, slot_a_float_emitter_sel, slot_b_float_emitter_sel;
  logic [13:0] sampleData;
  logic [4:0]  slot_a_float_pulse_width, slot_b_float_pulse_width;
  logic [3:0]  slot_a_exceed_flags, slot_b_exceed_flags;
  int          errors = 0, num_checks = 0, cycles = 0;
  fmbm_monitor u_dut (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // whole run is a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    {regAddr, regWriteData, regWrite} = {a, d, 1'b1};
    @(negedge clk);
    regWrite = 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(negedge clk);
    {regAddr, regRead} = {a, 1'b1};
    @(negedge clk);
    regRead = 1'b0;
    rd = regReadData;
  endtask
  // n back-to-back samples, n at least one
  task automatic smp(input logic b, input logic [1:0] ch, input logic [13:0] d, input int n);
    @(negedge clk);
    {sampleSlotB, sampleChannel, sampleData, sampleValid} = {b, ch, d, 1'b1};
    repeat (n) @(negedge clk);
    sampleValid = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK({slot_a_float_pulse_width, slot_a_float_first_pulse_delay}, {5'h03, 8'h20})
    `CHK({slot_b_float_pulse_width, slot_a_float_emitter_sel}, {5'h03, 2'h0})
    `CHK({slot_b_float_emitter_sel, slot_b_float_first_pulse_delay}, {2'h0, 8'h20})
    rdr(FMBM_ADDR_TIMING_A);
    `CHK(rd, 16'h0320)
    rdr(FMBM_ADDR_STATUS);
    `CHK(rd, 16'h0000)
  endtask
  task automatic t_timing();
    for (int s = 0; s < 4; s++) begin
      wr(FMBM_ADDR_TIMING_A, {s[1:0], 14'h3fff});
      `CHK(slot_a_float_emitter_sel, s[1:0])
      wr(FMBM_ADDR_TIMING_B, {~s[1:0], 14'h0a55});
      `CHK({slot_b_float_emitter_sel, slot_b_float_pulse_width}, {~s[1:0], 5'h0a})
    end
    `CHK({slot_a_float_pulse_width, slot_a_float_first_pulse_delay}, {5'h1f, 8'hff})
    rdr(FMBM_ADDR_TIMING_A);
    `CHK(rd, 16'hdfff)
    `CHK(slot_b_float_first_pulse_delay, 8'h55)
    rdr(FMBM_ADDR_TIMING_B);
    `CHK(rd, 16'h0a55)
  endtask
  task automatic t_count();
    logic [1:0] ch;
    int         need;
    for (int b = 0; b < 2; b++) begin
      for (int s = 1; s < 4; s++) begin
        ch = 2'(s - 1 + b);
        need = (s == 1) ? 1 : (s == 2) ? 4 : 16;
        wr(b ? FMBM_ADDR_THRESH_B : FMBM_ADDR_THRESH_A, {s[1:0], 14'h0100});
        rdr(b ? FMBM_ADDR_THRESH_B : FMBM_ADDR_THRESH_A);
        `CHK(rd, {s[1:0], 14'h0100})
        // equal to the limit is not a hit, and non-subtract samples are ignored
        smp(b[0], ch, 14'h0100, 3);
        sampleSubtract = 1'b0;
        smp(b[0], ch, 14'h3fff, 20);
        sampleSubtract = 1'b1;
        if (need > 1) smp(b[0], ch, 14'h0101, need - 1);
        `CHK({slot_b_exceed_flags, slot_a_exceed_flags}, 8'h00)
        smp(b[0], ch, 14'h0101, 1);
        rdr(FMBM_ADDR_STATUS);
        `CHK(rd, 16'(1 << (ch + 4 * b)))
        rdr(FMBM_ADDR_STATUS);
        `CHK(rd, 16'h0000)
      end
    end
  endtask
  task automatic t_restart();
    wr(FMBM_ADDR_THRESH_A, 16'h0100);
    smp(1'b0, 2'h3, 14'h3fff, 20);
    `CHK(slot_a_exceed_flags, 4'h0)
    wr(FMBM_ADDR_THRESH_A, 16'h8100);
    smp(1'b0, 2'h3, 14'h3fff, 3);
    rdr(FMBM_ADDR_STATUS);
    smp(1'b0, 2'h3, 14'h3fff, 3);
    `CHK(slot_a_exceed_flags, 4'h0)
    smp(1'b0, 2'h3, 14'h3fff, 1);
    `CHK(slot_a_exceed_flags, 4'h8)
  endtask
  // a hit landing in the status-read cycle must survive the clear
  task automatic t_clear_race();
    wr(FMBM_ADDR_THRESH_A, 16'h4100);
    @(negedge clk);
    {regAddr, regRead, sampleSlotB, sampleChannel, sampleData, sampleValid} =
      {FMBM_ADDR_STATUS, 1'b1, 1'b0, 2'h2, 14'h3fff, 1'b1};
    @(negedge clk);
    {regRead, sampleValid} = 2'h0;
    `CHK(regReadData, 16'h0008)
    `CHK(slot_a_exceed_flags, 4'h4)
  endtask
  initial begin
    {reset, regWrite, regRead, sampleValid, sampleSubtract, sampleSlotB} = 6'h22;
    {regAddr, regWriteData, sampleChannel, sampleData} = '0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_timing();
    t_count();
    t_restart();
    t_clear_race();
    test_done();
  end
endmodule
